// file: can_tx_flags_pkg.sv
// Constants shared by the transmit buffer flag logic of the CAN controller.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package can_tx_flags_pkg;
    // Buffer count and register widths
    localparam int NUM_BUF = 3;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] TX_BUFFER_EMPTY_FLAGS_OFS = 8'h00;
    localparam logic [7:0] TX_EMPTY_IRQ_ENABLE_OFS = 8'h04;
    localparam logic [7:0] TX_ABORT_REQUEST_OFS = 8'h08;
    localparam logic [7:0] TX_ABORT_ACKNOWLEDGE_OFS = 8'h0c;
    localparam logic [7:0] MODE_CONTROL_OFS = 8'h10;
    localparam logic [7:0] LINK_STATUS_OFS = 8'h14;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'h18;
    localparam logic [7:0] EVENT_MASK_OFS = 8'h1c;
    localparam logic [7:0] MAP_END_OFS = 8'h20;

    // Mode control fields
    localparam int CTL_INIT_REQUEST_BIT = 0;
    localparam int CTL_LISTEN_ONLY_BIT = 1;

    // Link status fields
    localparam int STS_INIT_ACK_BIT = 0;
    localparam int STS_TX_BUS_OFF_BIT = 1;
    localparam int STS_RX_STATE_LSB = 2;

    // Event status and mask fields
    localparam int EVT_SENT_BIT = 0;
    localparam int EVT_ABORTED_BIT = 1;
    localparam int EVT_BLOCKED_BIT = 2;
    localparam int NUM_EVT = 3;

    // Reset values
    localparam logic [2:0] EMPTY_FLAGS_RESET = 3'h7;
    localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
    localparam logic [2:0] ABORT_REQ_RESET = 3'h0;
    localparam logic [2:0] ABORT_ACK_RESET = 3'h0;
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam logic [2:0] EVENT_RESET = 3'h0;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Receiver state encoding, bus-off included for the forced recovery path
    typedef enum logic [1:0] {
        RX_ERROR_FREE = 2'h0,
        RX_WARNING = 2'h1,
        RX_ERROR = 2'h2,
        RX_BUS_OFF = 2'h3
    } receiver_state_e;
endpackage

// file: can_tx_buffer_flags_abort.sv
// Transmit buffer empty flags, interrupt enables, abort request and
// abort acknowledge for three CAN transmit buffers, behind AXI4-Lite.
// Assumes the protocol engine reports sends, failures and bus state as
// single-cycle pulses and levels synchronous to core_clk.
//
// Overview of operation
// - Three empty flags, one per buffer, set while buffer holds nothing scheduled.
// - A successful send sets the buffer's empty flag again.
// - Transmit interrupt pending while any enabled buffer's empty flag is set.
// - Clearing an empty flag also clears that buffer's abort acknowledge.
// - An empty flag becoming set clears that buffer's abort request.
// - Listen-only mode ignores empty flag clears and starts no transmission.
// - Buffer accesses are blocked while the buffer is scheduled.
// - Init mode holds flags, enables and abort requests at reset values.
// - Those registers take writes only outside init; reads always allowed.
// - Writing one clears an empty flag; writing zero leaves it.
// - Per-buffer enable bit decides whether an empty buffer requests an interrupt.
// - Abort granted only before transmission starts, or after lost arbitration or error.
// - A granted abort sets empty and acknowledge flags and may raise interrupt.
// - Software writes cannot clear abort request; only the empty flag setting or init mode does.
// - Transmitter leaving bus-off forces receiver state straight to error-free.
// - Acknowledge set means buffer emptied by honoured abort, not by sending.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
module can_tx_buffer_flags_abort #(
    parameter int ADDR_W = can_tx_flags_pkg::ADDR_W
) (
    input wire logic core_clk, // Controller clock
    input wire logic srst, // Synchronous reset, active high
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    // Protocol engine side
    input wire logic initAcknowledge, // Engine confirms init mode
    input wire logic [2:0] txSentPulse, // Buffer sent successfully, pulse
    input wire logic [2:0] txFailPulse, // Lost arbitration or error, pulse
    input wire logic [2:0] txActive, // Buffer transmission in progress
    input wire logic txBusOff, // Transmitter in bus-off
    input wire logic [1:0] rxStateIn, // Receiver state from engine
    output logic [2:0] txScheduled, // Buffers the engine may send
    output logic [2:0] abortPending, // Abort request bits
    output logic initRequest, // Init mode request to engine
    output logic [1:0] receiverStateCode, // Receiver state, bus-off coded
    // Transmit buffer access port
    input wire logic bufAccessReq, // Buffer access attempt, pulse
    input wire logic [1:0] bufAccessIdx, // Buffer being accessed
    output logic bufAccessGrant, // Access allowed, pulse
    output logic bufAccessBlocked, // Access refused, pulse
    // Interrupts
    output logic txIrq, // Transmit empty interrupt request
    output logic irq // Masked event interrupt
);

    localparam int NB = can_tx_flags_pkg::NUM_BUF;

    logic [2:0] emptyFlags_reg;
    logic [2:0] irqEnable_reg;
    logic [2:0] abortReq_reg;
    logic [2:0] abortAck_reg;
    logic initRequest_reg;
    logic listenOnly_reg;
    logic [2:0] eventStatus_reg;
    logic [2:0] eventMask_reg;
    logic txBusOffPrev_reg;
    logic [1:0] rxState_reg;

    logic awHeld_reg;
    logic wHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic awReady_reg;
    logic wReady_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic arReady_reg;
    logic rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0] rResp_reg;

    logic [2:0] txScheduled_reg;
    logic bufGrant_reg;
    logic bufBlocked_reg;
    logic txIrq_reg;
    logic irq_reg;

    logic initMode;
    logic writeAllowed;
    logic writeFire;
    logic lane0;
    logic [7:0] wAddrByte;
    logic [7:0] rAddrByte;
    logic wrFlags;
    logic wrEnable;
    logic wrAbort;
    logic wrControl;
    logic wrEvtStatus;
    logic wrEvtMask;
    logic wrMapped;
    logic [2:0] emptySet;
    logic [2:0] emptyClr;
    logic [2:0] abortGrant;
    logic [2:0] eventSet;
    logic accessBlocked;

    // Address bytes widened or cut to the decode width
    assign wAddrByte = 8'(awAddr_reg);
    assign rAddrByte = 8'(s_axi_araddr);

    // Init mode is entered only once the engine has acknowledged
    assign initMode = initRequest_reg & initAcknowledge;
    assign writeAllowed = ~initRequest_reg & ~initAcknowledge;

    // Write takes effect once both address and data are held
    assign writeFire = awHeld_reg & wHeld_reg & ~bValid_reg;
    assign lane0 = wStrb_reg[0];
    assign wrMapped = wAddrByte < can_tx_flags_pkg::MAP_END_OFS;
    assign wrFlags = writeFire & lane0 & (wAddrByte == can_tx_flags_pkg::TX_BUFFER_EMPTY_FLAGS_OFS);
    assign wrEnable = writeFire & lane0 & (wAddrByte == can_tx_flags_pkg::TX_EMPTY_IRQ_ENABLE_OFS);
    assign wrAbort = writeFire & lane0 & (wAddrByte == can_tx_flags_pkg::TX_ABORT_REQUEST_OFS);
    assign wrControl = writeFire & lane0 & (wAddrByte == can_tx_flags_pkg::MODE_CONTROL_OFS);
    assign wrEvtStatus = writeFire & lane0 & (wAddrByte == can_tx_flags_pkg::EVENT_STATUS_OFS);
    assign wrEvtMask = writeFire & lane0 & (wAddrByte == can_tx_flags_pkg::EVENT_MASK_OFS);

    // Per-buffer set, clear and abort grant terms
    generate
        for (genvar i = 0; i < NB; i++) begin : g_buf
            // Grant only before start, or after a failed attempt
            assign abortGrant[i] = abortReq_reg[i] & ~emptyFlags_reg[i]
                & (~txActive[i] | txFailPulse[i]);
            // Either a send or a granted abort empties the buffer
            assign emptySet[i] = (txSentPulse[i] & ~emptyFlags_reg[i]) | abortGrant[i];
            // Listen-only silently drops the clear
            assign emptyClr[i] = wrFlags & writeAllowed & ~listenOnly_reg & wData_reg[i];
        end
    endgenerate

    // Buffer access check against the scheduled state
    assign accessBlocked = (bufAccessIdx < 2'(NB)) ? ~emptyFlags_reg[bufAccessIdx] : 1'b1;

    // Events feeding the sticky status register
    assign eventSet[can_tx_flags_pkg::EVT_SENT_BIT] = |(txSentPulse & ~emptyFlags_reg);
    assign eventSet[can_tx_flags_pkg::EVT_ABORTED_BIT] = |abortGrant;
    assign eventSet[can_tx_flags_pkg::EVT_BLOCKED_BIT] = bufAccessReq & accessBlocked;

    // Empty flags; a hardware set wins over a same-cycle clear
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NB; i++) begin
            if (srst || initMode) begin
                emptyFlags_reg[i] <= can_tx_flags_pkg::EMPTY_FLAGS_RESET[i];
            end else if (emptySet[i]) begin
                emptyFlags_reg[i] <= 1'b1;
            end else if (emptyClr[i]) begin
                emptyFlags_reg[i] <= 1'b0;
            end
        end
    end

    // Interrupt enables, plain read-write
    always_ff @(posedge core_clk) begin
        if (srst || initMode) begin
            irqEnable_reg <= can_tx_flags_pkg::IRQ_ENABLE_RESET;
        end else if (wrEnable && writeAllowed) begin
            irqEnable_reg <= wData_reg[2:0];
        end
    end

    // Abort requests; software can only set, the empty flag clears
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NB; i++) begin
            if (srst || initMode) begin
                abortReq_reg[i] <= can_tx_flags_pkg::ABORT_REQ_RESET[i];
            end else if (emptySet[i]) begin
                abortReq_reg[i] <= 1'b0;
            end else if (wrAbort && writeAllowed && wData_reg[i]) begin
                abortReq_reg[i] <= 1'b1;
            end
        end
    end

    // Abort acknowledge tells an honoured abort from a real send
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NB; i++) begin
            if (srst || initMode) begin
                abortAck_reg[i] <= can_tx_flags_pkg::ABORT_ACK_RESET[i];
            end else if (abortGrant[i]) begin
                abortAck_reg[i] <= 1'b1;
            end else if (emptyClr[i]) begin
                abortAck_reg[i] <= 1'b0;
            end
        end
    end

    // Mode control, writable at any time so init can be left
    always_ff @(posedge core_clk) begin
        if (srst) begin
            initRequest_reg <= can_tx_flags_pkg::CONTROL_RESET[can_tx_flags_pkg::CTL_INIT_REQUEST_BIT];
            listenOnly_reg <= can_tx_flags_pkg::CONTROL_RESET[can_tx_flags_pkg::CTL_LISTEN_ONLY_BIT];
        end else if (wrControl) begin
            initRequest_reg <= wData_reg[can_tx_flags_pkg::CTL_INIT_REQUEST_BIT];
            listenOnly_reg <= wData_reg[can_tx_flags_pkg::CTL_LISTEN_ONLY_BIT];
        end
    end

    // Receiver state tracking with forced recovery out of bus-off
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txBusOffPrev_reg <= 1'b0;
            rxState_reg <= can_tx_flags_pkg::RX_ERROR_FREE;
        end else begin
            txBusOffPrev_reg <= txBusOff;
            if (txBusOffPrev_reg && !txBusOff) begin
                rxState_reg <= can_tx_flags_pkg::RX_ERROR_FREE;
            end else if (txBusOff) begin
                rxState_reg <= can_tx_flags_pkg::RX_BUS_OFF;
            end else begin
                rxState_reg <= rxStateIn;
            end
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            eventStatus_reg <= can_tx_flags_pkg::EVENT_RESET;
        end else begin
            for (int i = 0; i < can_tx_flags_pkg::NUM_EVT; i++) begin
                if (eventSet[i]) begin
                    eventStatus_reg[i] <= 1'b1;
                end else if (wrEvtStatus && wData_reg[i]) begin
                    eventStatus_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Event mask
    always_ff @(posedge core_clk) begin
        if (srst) begin
            eventMask_reg <= can_tx_flags_pkg::EVENT_RESET;
        end else if (wrEvtMask) begin
            eventMask_reg <= wData_reg[2:0];
        end
    end

    // Registered outputs toward the engine and the CPU
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txScheduled_reg <= 3'h0;
            txIrq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            // Nothing is offered for sending in listen-only mode
            txScheduled_reg <= listenOnly_reg ? 3'h0 : ~emptyFlags_reg;
            txIrq_reg <= |(emptyFlags_reg & irqEnable_reg);
            irq_reg <= |(eventStatus_reg & eventMask_reg);
        end
    end

    // Buffer access answer, one cycle after the attempt
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bufGrant_reg <= 1'b0;
            bufBlocked_reg <= 1'b0;
        end else begin
            bufGrant_reg <= bufAccessReq & ~accessBlocked;
            bufBlocked_reg <= bufAccessReq & accessBlocked;
        end
    end

    // Write address channel; held until the write fires, ready again once the response is taken
    always_ff @(posedge core_clk) begin
        if (srst) begin
            awHeld_reg <= 1'b0;
            awReady_reg <= 1'b0;
            awAddr_reg <= '0;
        end else if (s_axi_awvalid && awReady_reg) begin
            awHeld_reg <= 1'b1;
            awReady_reg <= 1'b0;
            awAddr_reg <= s_axi_awaddr;
        end else if (writeFire) begin
            awHeld_reg <= 1'b0;
        end else if (!awHeld_reg && !bValid_reg) begin
            awReady_reg <= 1'b1;
        end
    end

    // Write data channel, independent of the address channel
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wHeld_reg <= 1'b0;
            wReady_reg <= 1'b0;
            wData_reg <= 32'h0;
            wStrb_reg <= 4'h0;
        end else if (s_axi_wvalid && wReady_reg) begin
            wHeld_reg <= 1'b1;
            wReady_reg <= 1'b0;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end else if (writeFire) begin
            wHeld_reg <= 1'b0;
        end else if (!wHeld_reg && !bValid_reg) begin
            wReady_reg <= 1'b1;
        end
    end

    // Write response; locked registers still answer OKAY
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bValid_reg <= 1'b0;
            bResp_reg <= can_tx_flags_pkg::RESP_OKAY;
        end else if (writeFire) begin
            bValid_reg <= 1'b1;
            bResp_reg <= wrMapped ? can_tx_flags_pkg::RESP_OKAY : can_tx_flags_pkg::RESP_SLVERR;
        end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end

    // Read channel; data sampled at the address handshake
    always_ff @(posedge core_clk) begin
        if (srst) begin
            arReady_reg <= 1'b0;
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0;
            rResp_reg <= can_tx_flags_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arReady_reg) begin
            arReady_reg <= 1'b0;
            rValid_reg <= 1'b1;
            rResp_reg <= can_tx_flags_pkg::RESP_OKAY;
            unique case (rAddrByte)
                can_tx_flags_pkg::TX_BUFFER_EMPTY_FLAGS_OFS: rData_reg <= {29'h0, emptyFlags_reg};
                can_tx_flags_pkg::TX_EMPTY_IRQ_ENABLE_OFS: rData_reg <= {29'h0, irqEnable_reg};
                can_tx_flags_pkg::TX_ABORT_REQUEST_OFS: rData_reg <= {29'h0, abortReq_reg};
                can_tx_flags_pkg::TX_ABORT_ACKNOWLEDGE_OFS: rData_reg <= {29'h0, abortAck_reg};
                can_tx_flags_pkg::MODE_CONTROL_OFS: rData_reg <= {30'h0, listenOnly_reg, initRequest_reg};
                can_tx_flags_pkg::LINK_STATUS_OFS: rData_reg <= {28'h0, rxState_reg, txBusOffPrev_reg,
                    initAcknowledge};
                can_tx_flags_pkg::EVENT_STATUS_OFS: rData_reg <= {29'h0, eventStatus_reg};
                can_tx_flags_pkg::EVENT_MASK_OFS: rData_reg <= {29'h0, eventMask_reg};
                default: begin
                    // Unmapped reads return zero with an error
                    rData_reg <= 32'h0;
                    rResp_reg <= can_tx_flags_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
            arReady_reg <= 1'b1;
        end else if (!rValid_reg) begin
            arReady_reg <= 1'b1;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awReady_reg;
    assign s_axi_wready = wReady_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;
    assign txScheduled = txScheduled_reg;
    assign abortPending = abortReq_reg;
    assign initRequest = initRequest_reg;
    assign receiverStateCode = rxState_reg;
    assign bufAccessGrant = bufGrant_reg;
    assign bufAccessBlocked = bufBlocked_reg;
    assign txIrq = txIrq_reg;
    assign irq = irq_reg;

endmodule

// file: can_tx_flags_props.sv
// Property checker for the transmit buffer flag block.
// Sees only top-level ports; bound to every instance below.
module can_tx_flags_props (
    input wire logic core_clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic initRequest, // Init request
    input wire logic initAcknowledge, // Init confirm
    input wire logic [2:0] txSentPulse, // Send done
    input wire logic [2:0] txActive, // Sending
    input wire logic [2:0] txScheduled, // Offered buffers
    input wire logic [2:0] abortPending, // Abort bits
    input wire logic txIrq, // Empty interrupt
    input wire logic txBusOff, // Bus-off
    input wire logic [1:0] rxStateIn, // Receiver state in
    input wire logic [1:0] receiverStateCode, // Receiver state out
    input wire logic bufAccessReq, // Access try
    input wire logic [1:0] bufAccessIdx, // Access index
    input wire logic bufAccessGrant, // Access allowed
    input wire logic bufAccessBlocked // Access refused
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // A freed buffer drops its abort bit first, then leaves the offered set
    sequence freed(int i);
        !abortPending[i] ##1 !txScheduled[i];
    endsequence
    // Two samples in init, so the forced values have reached the outputs
    sequence inInit;
        (initRequest && initAcknowledge)[*2];
    endsequence
    for (genvar i = 0; i < 3; i++) begin : g_buf
        sent_frees_a: assert property (txSentPulse[i] && txScheduled[i] |=> freed(i))
            else $error("sent buffer not freed");
        idle_abort_a: assert property (abortPending[i] && txScheduled[i] && !txActive[i] |=> freed(i))
            else $error("idle abort not granted");
    end
    init_holds_a: assert property (inInit |=> abortPending == 3'h0 && txScheduled == 3'h0 && !txIrq)
        else $error("init did not hold reset values");
    busoff_code_a: assert property (txBusOff |=> receiverStateCode == 2'h3)
        else $error("bus-off not coded");
    rx_recover_a: assert property ($fell(txBusOff) |=> receiverStateCode == 2'h0)
        else $error("receiver not forced error-free");
    rx_follow_a: assert property (!srst && !txBusOff && !$fell(txBusOff) |=> receiverStateCode == $past(rxStateIn))
        else $error("receiver state not followed");
    bad_index_a: assert property (bufAccessReq && bufAccessIdx == 2'h3 |=> bufAccessBlocked && !bufAccessGrant)
        else $error("bad index not blocked");
    access_answer_a: assert property (1'b1 |=> (bufAccessGrant || bufAccessBlocked) == $past(bufAccessReq))
        else $error("access answer wrong");
endmodule
bind can_tx_buffer_flags_abort can_tx_flags_props props (.*);

// file: can_engine_model.sv
// Protocol engine stand-in: confirms init, ends offered sends on command.
// Assumes bench commands change just after a rising edge.
module can_engine_model (
    input wire logic core_clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic initRequest, // Init request
    input wire logic [2:0] txScheduled, // Offered buffers
    input wire logic [2:0] sendCmd, // Finish these sends
    input wire logic [2:0] failCmd, // Fail these sends
    input wire logic [2:0] busyCmd, // Hold these on the bus
    output logic initAcknowledge, // Init confirmed
    output logic [2:0] txSentPulse, // Send done
    output logic [2:0] txFailPulse, // Send failed
    output logic [2:0] txActive // Sending
);
    timeunit 1ns;
    timeprecision 1ns;
    // Only offered buffers finish; a withdrawn buffer is never sent
    always_ff @(posedge core_clk) begin
        initAcknowledge <= !srst && initRequest;
        txSentPulse <= srst ? 3'h0 : sendCmd & txScheduled;
        txFailPulse <= srst ? 3'h0 : failCmd & txScheduled;
        txActive <= srst ? 3'h0 : busyCmd & txScheduled;
    end
endmodule

// file: tb_can_tx_buffer_flags_abort.sv
// Self-checking bench for the transmit buffer flag block.
// Assumes the engine model and the bound checker are compiled alongside.
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin failCount++; \
    $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module tb_can_tx_buffer_flags_abort;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'h0, srst = 1'h1, txBusOff = 1'h0, bufAccessReq = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic initAcknowledge, initRequest, bufAccessGrant, bufAccessBlocked, txIrq, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0; // Protection unused
    logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
    logic [1:0] s_axi_bresp, s_axi_rresp, receiverStateCode, bufAccessIdx = 2'h0, rxStateIn = 2'h2;
    logic [2:0] txSentPulse, txFailPulse, txActive, txScheduled, abortPending;
    logic [2:0] sendCmd = 3'h0, failCmd = 3'h0, busyCmd = 3'h0;
    int failCount = 0, samplesChecked = 0, cycles = 0;
    can_tx_buffer_flags_abort uut (.*);
    can_engine_model engine (.*);
    // 10 MHz clock
    always #50 core_clk = ~core_clk;
    // Hang guard; the run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One write; bready rides with the request so the answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, er)
    endtask
    // One read, compared on the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
    endtask
    // Settle past the edge so registered outputs have landed
    task automatic go(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Access answer stands only in the cycle after the request
    task automatic acc(input logic [1:0] idx, input logic blk);
        @(posedge core_clk);
        bufAccessReq <= 1'h1;
        bufAccessIdx <= idx;
        go(1);
        bufAccessReq <= 1'h0;
        `CHK(bufAccessBlocked, blk)
        `CHK(bufAccessGrant, !blk)
    endtask
    // Reset values, scheduling, sending, buffer access and event interrupt
    task automatic t_send();
        rd(8'h00, 32'h7);
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h20, 32'h1, 2'h2);
        wr(8'h04, 32'h1);
        wr(8'h1c, 32'h1);
        wr(8'h00, 32'h0);
        `CHK(txIrq, 1'h1)
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h6);
        `CHK(txIrq, 1'h0)
        wr(8'h04, 32'h7);
        go(1);
        `CHK(txIrq, 1'h1)
        acc(2'h0, 1'h1);
        acc(2'h1, 1'h0);
        acc(2'h3, 1'h1);
        @(posedge core_clk) sendCmd <= 3'h1;
        @(posedge core_clk) sendCmd <= 3'h0;
        rd(8'h00, 32'h7);
        `CHK(irq, 1'h1)
        wr(8'h18, 32'h1);
        wr(8'h04, 32'h0);
        `CHK(irq, 1'h0)
    endtask
    // Abort held while sending, granted on failure, then granted while idle
    task automatic t_abort();
        @(posedge core_clk) busyCmd <= 3'h4;
        wr(8'h00, 32'h4);
        wr(8'h08, 32'h4);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h4);
        rd(8'h00, 32'h3);
        @(posedge core_clk) failCmd <= 3'h4;
        @(posedge core_clk) failCmd <= 3'h0;
        rd(8'h00, 32'h7);
        rd(8'h0c, 32'h4);
        rd(8'h08, 32'h0);
        rd(8'h18, 32'h6);
        `CHK(irq, 1'h0)
        @(posedge core_clk) busyCmd <= 3'h0;
        wr(8'h00, 32'h4);
        rd(8'h0c, 32'h0);
        wr(8'h08, 32'h4);
        rd(8'h0c, 32'h4);
        rd(8'h00, 32'h7);
        wr(8'h18, 32'h7);
    endtask
    // Listen-only withdraws offers and ignores flag clears
    task automatic t_listen();
        @(posedge core_clk) busyCmd <= 3'h2;
        wr(8'h00, 32'h2);
        wr(8'h10, 32'h2);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h5);
        `CHK(txScheduled, 3'h0)
        wr(8'h10, 32'h0);
        go(2);
        `CHK(txScheduled, 3'h2)
    endtask
    // Init forces flags, enables and aborts and locks writes
    task automatic t_init();
        wr(8'h08, 32'h2);
        wr(8'h04, 32'h7);
        rd(8'h08, 32'h2);
        wr(8'h10, 32'h1);
        `CHK(initRequest, 1'h1)
        rd(8'h00, 32'h7);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h7);
        rd(8'h04, 32'h0);
        rd(8'h14, 32'h9);
        wr(8'h10, 32'h0);
        wr(8'h04, 32'h5);
        rd(8'h04, 32'h5);
        @(posedge core_clk) busyCmd <= 3'h0;
    endtask
    // Leaving bus-off skips the receiver straight to error-free
    task automatic t_busoff();
        @(posedge core_clk) txBusOff <= 1'h1;
        rd(8'h14, 32'he);
        @(posedge core_clk) txBusOff <= 1'h0;
        go(1);
        `CHK(receiverStateCode, 2'h0)
        go(2);
        `CHK(receiverStateCode, 2'h2)
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'h0;
        t_send();
        t_abort();
        t_listen();
        t_init();
        t_busoff();
        conclude();
    end
endmodule
